// *** rtl/sdc_ctrl.sv ***
`timescale 1ns/100ps
// Write data buffer between client and memory burst engine
module sdc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q, cnt_d;
  logic in_ready_q;
  logic push, pop;
  assign push = in_valid && in_ready_q;
  assign pop = out_valid && out_ready;
  assign in_ready = in_ready_q;
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rp_q];
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  // Storage needs no reset, only pointers, count and ready do
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
  // Pointers and registered ready, so the client sees a flop
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      in_ready_q <= 1'b0;
    end else begin
      if (push) wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      if (pop) rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      cnt_q <= cnt_d;
      in_ready_q <= cnt_d != (AW+1)'(DEPTH);
    end
  end
endmodule : sdc_fifo

module sdc_ctrl import sdc_pkg::*; (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [2:0] cmd_op,
  input wire logic [BANK_BITS-1:0] cmd_bank,
  input wire logic [ROW_BITS-1:0] cmd_row,
  input wire logic [COL_ADDR_BITS-1:0] cmd_col,
  input wire logic [COL_ADDR_BITS-1:0] cmd_words,
  output logic cmd_done,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WORD_BITS-1:0] wr_data,
  output logic rd_valid,
  output logic [WORD_BITS-1:0] rd_data,
  output logic mem_clk,
  output logic mem_cke,
  output logic mem_cs_n,
  output logic mem_ras_n,
  output logic mem_cas_n,
  output logic mem_we_n,
  output logic [BANK_BITS-1:0] mem_ba,
  output logic mem_dqm,
  output logic [AD_BITS-1:0] mem_ad_out,
  input wire logic [AD_BITS-1:0] mem_ad_in,
  output logic mem_ad_oe_n
);
  localparam int CLK_PER = 2 * CLK_DIV;
  localparam int NW = COL_ADDR_BITS + 1;
  localparam int TW = COL_ADDR_BITS + 2;

  // Command enable decode, shared by the idle dispatch and checks
  function automatic logic op_enabled(input logic [2:0] op);
    case (op)
      OP_WAIT: op_enabled = EN_WAIT;
      OP_BUF_READ: op_enabled = EN_BUF_READ;
      OP_BUF_WRITE: op_enabled = EN_BUF_WRITE;
      OP_ROW_READ: op_enabled = EN_ROW_READ;
      OP_ROW_WRITE: op_enabled = EN_ROW_WRITE;
      default: op_enabled = 1'b0;
    endcase
  endfunction : op_enabled

  sdc_state_t state_q;
  logic [3:0] div_q;
  logic clk_q, cke_q, cs_n_q, dqm_q, oe_n_q;
  logic [2:0] mc_q;
  logic [BANK_BITS-1:0] ba_q;
  logic [AD_BITS-1:0] ad_q;
  logic ready_q, done_q, rvalid_q, pend_q, hi_q, wr_op_q;
  logic [2:0] op_q;
  logic [ROW_BITS-1:0] row_q;
  logic [COL_ADDR_BITS-1:0] col_q;
  logic [NW-1:0] rem_q;
  logic [TW-1:0] t_q;
  logic [3:0] gap_q;
  logic [COL_BITS-1:0] lo_q;
  logic [WORD_BITS-1:0] rdata_q;
  logic [OWED_W-1:0] owed_q;
  logic [8:0] per_q;
  logic [11:0] init_q;
  logic init_done_q;
  logic tick, go, take, per_wrap, ref_dec, ref_due, f_valid, f_pop, mrs_go;
  logic [WORD_BITS-1:0] f_data;

  assign tick = (div_q == 4'(CLK_DIV - 1)) && clk_q;
  assign go = tick && (gap_q == '0);
  assign take = cmd_valid && ready_q;
  assign per_wrap = per_q == 9'(REF_PERIOD_CYC - 1);
  assign ref_dec = go && (state_q == ST_REF) && (owed_q != '0);
  assign ref_due = owed_q >= OWED_W'(MAX_REFRESH_GAP);
  assign f_pop = go && (state_q == ST_WDATA) && hi_q && f_valid;
  assign mrs_go = go && (state_q == ST_MRS);

  // Client words wait here; full FIFO stalls the client
  sdc_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_wfifo (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  // Memory clock toggles every CLK_DIV reference cycles
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= '0;
      clk_q <= 1'b0;
    end else if (div_q == 4'(CLK_DIV - 1)) begin
      div_q <= '0;
      clk_q <= ~clk_q;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // Power-up wait before the first memory command
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      init_q <= '0;
      init_done_q <= 1'b0;
    end else if (init_q == 12'(INIT_CYC - 1)) begin
      init_done_q <= 1'b1;
    end else begin
      init_q <= init_q + 1'b1;
    end
  end

  // Owed refreshes keep accruing during a transfer so the next burst grows
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      per_q <= '0;
      owed_q <= OWED_W'(MAX_REFRESH_GAP); // Start-up burst covers init refreshes
    end else begin
      per_q <= per_wrap ? '0 : per_q + 1'b1;
      owed_q <= owed_q + OWED_W'(per_wrap) - OWED_W'(ref_dec);
    end
  end

  // Command acceptance; refused while a refresh is due or work is pending
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_q <= 1'b0;
      pend_q <= 1'b0;
      op_q <= OP_WAIT;
    end else begin
      ready_q <= (state_q == ST_IDLE) && !pend_q && !take && !ref_due;
      if (take) begin
        pend_q <= 1'b1;
        op_q <= cmd_op;
      end else if (go && state_q == ST_IDLE) begin
        pend_q <= 1'b0;
      end
    end
  end

  // Main sequencer; command pins change at the falling memory clock edge, mem_ba when a command is taken
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_INIT;
      cke_q <= 1'b0;
      cs_n_q <= 1'b1;
      mc_q <= MC_NOP;
      ba_q <= '0;
      ad_q <= '0;
      dqm_q <= 1'b1;
      oe_n_q <= 1'b1;
      gap_q <= '0;
      done_q <= 1'b0;
      rvalid_q <= 1'b0;
      hi_q <= 1'b0;
      wr_op_q <= 1'b0;
      row_q <= '0;
      col_q <= '0;
      rem_q <= '0;
      t_q <= '0;
      lo_q <= '0;
      rdata_q <= '0;
    end else begin
      done_q <= 1'b0;
      rvalid_q <= 1'b0;
      cke_q <= 1'b1;
      cs_n_q <= 1'b0;
      if (take) begin
        ba_q <= cmd_bank;
        row_q <= cmd_row;
        wr_op_q <= (cmd_op == OP_BUF_WRITE) || (cmd_op == OP_ROW_WRITE);
        if (cmd_op == OP_ROW_READ || cmd_op == OP_ROW_WRITE) begin
          col_q <= '0;
          rem_q <= NW'(2 * ROW_WORDS);
        end else begin
          col_q <= cmd_col;
          rem_q <= {cmd_words, 1'b0};
        end
      end
      if (tick) begin
        mc_q <= MC_NOP;
        if (gap_q != '0) begin
          gap_q <= gap_q - 1'b1;
        end else begin
          case (state_q)
            ST_INIT: begin
              if (init_done_q) begin
                mc_q <= MC_PRE;
                ad_q <= PRE_ALL_AD;
                oe_n_q <= 1'b0;
                gap_q <= 4'(TRP_TICKS);
                state_q <= ST_MRS;
              end
            end
            ST_MRS: begin
              mc_q <= MC_MRS;
              ad_q <= MODE_REG;
              gap_q <= 4'(TMRD_TICKS);
              state_q <= ST_IDLE;
            end
            ST_IDLE: begin
              // Bus left to others only when shared access is built in
              oe_n_q <= SHARED_ACCESS_OPTION;
              // A taken command runs first, so a refresh never finds work pending
              if (pend_q) begin
                if (op_q == OP_WAIT || !op_enabled(op_q)) begin
                  done_q <= 1'b1;
                end else begin
                  mc_q <= MC_ACT;
                  ad_q <= AD_BITS'(row_q);
                  oe_n_q <= 1'b0;
                  gap_q <= 4'(TRCD_TICKS - 1);
                  state_q <= ST_XCMD;
                end
              end else if (ref_due && !take) begin
                state_q <= ST_REF;
              end
            end
            ST_REF: begin
              if (owed_q == '0) begin
                state_q <= ST_IDLE;
              end else begin
                mc_q <= MC_REF;
                gap_q <= 4'(MIN_REFRESH_SPACING - 1);
              end
            end
            ST_XCMD: begin
              if (!wr_op_q) begin
                mc_q <= MC_READ;
                ad_q <= AD_BITS'(col_q);
                t_q <= TW'(1);
                hi_q <= 1'b0;
                state_q <= ST_RDATA;
              end else if (f_valid) begin
                // Burst opens one column early with that column masked
                mc_q <= MC_WRITE;
                // Wrap inside the column field so the upper address bits stay clear
                ad_q <= AD_BITS'(COL_ADDR_BITS'(col_q - 1'b1));
                dqm_q <= 1'b1;
                hi_q <= 1'b0;
                state_q <= ST_WDATA;
              end
            end
            ST_WDATA: begin
              if (!hi_q && !f_valid) begin
                // Underrun: halt the burst and reopen when data arrives
                mc_q <= MC_BST;
                dqm_q <= 1'b1;
                state_q <= ST_XCMD;
              end else begin
                ad_q <= hi_q ? f_data[WORD_BITS-1:COL_BITS] : f_data[COL_BITS-1:0];
                dqm_q <= 1'b0;
                hi_q <= ~hi_q;
                col_q <= col_q + 1'b1;
                rem_q <= rem_q - 1'b1;
                if (rem_q == NW'(1)) begin
                  state_q <= ST_STOP;
                end
              end
            end
            ST_STOP: begin
              mc_q <= MC_BST;
              dqm_q <= 1'b1;
              gap_q <= 4'(TWR_TICKS - 1);
              state_q <= ST_CLOSE;
            end
            ST_RDATA: begin
              oe_n_q <= 1'b1;
              t_q <= t_q + 1'b1;
              if (t_q == TW'(rem_q)) begin
                mc_q <= MC_BST;
              end
              if (t_q >= TW'(CAS_LAT)) begin
                hi_q <= ~hi_q;
                if (hi_q) begin
                  rdata_q <= {mem_ad_in, lo_q};
                  rvalid_q <= 1'b1;
                end else begin
                  lo_q <= mem_ad_in;
                end
              end
              if (t_q == TW'(rem_q) + TW'(CAS_LAT - 1)) begin
                state_q <= ST_CLOSE;
              end
            end
            ST_CLOSE: begin
              mc_q <= MC_PRE;
              ad_q <= PRE_ALL_AD;
              oe_n_q <= 1'b0;
              dqm_q <= 1'b0;
              gap_q <= 4'(TRP_TICKS - 1);
              done_q <= 1'b1;
              state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
          endcase
        end
      end
    end
  end

  assign cmd_ready = ready_q;
  assign cmd_done = done_q;
  assign rd_valid = rvalid_q;
  assign rd_data = rdata_q;
  assign mem_clk = clk_q;
  assign mem_cke = cke_q;
  assign mem_cs_n = cs_n_q;
  assign {mem_ras_n, mem_cas_n, mem_we_n} = mc_q;
  assign mem_ba = ba_q;
  assign mem_dqm = dqm_q;
  assign mem_ad_out = ad_q;
  assign mem_ad_oe_n = oe_n_q;

  // Checks
  a_ref_not_busy: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ref_dec |-> !pend_q && (state_q == ST_REF)) else $error("refresh during transfer");
  a_ref_spacing: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ref_dec |=> !ref_dec [*3]) else $error("refreshes too close");
  a_burst_grows: assert property (@(posedge ref_clk) disable iff (!arst_n)
    per_wrap && !ref_dec |=> owed_q == $past(owed_q) + 1'b1) else $error("owed lost");
  a_owed_bound: assert property (@(posedge ref_clk) disable iff (!arst_n)
    owed_q <= OWED_W'(REFRESH_CYCLES)) else $error("refresh debt overflow");
  a_clk_period: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(clk_q) |-> ##CLK_PER $rose(clk_q)) else $error("memory clock period");
  a_mode_load: assert property (@(posedge ref_clk) disable iff (!arst_n)
    mrs_go |=> (mc_q == MC_MRS) && (ad_q == MODE_REG)) else $error("mode value");
  a_ready_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ready_q |-> (state_q == ST_IDLE) && !pend_q) else $error("ready while busy");
  a_row_col0: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && (cmd_op == OP_ROW_READ) |=> (col_q == '0) && (rem_q == NW'(2 * ROW_WORDS)))
    else $error("full row start");
  a_disabled_op: assert property (@(posedge ref_clk) disable iff (!arst_n)
    go && state_q == ST_IDLE && pend_q && !ref_due && !op_enabled(op_q)
    |=> done_q && (mc_q == MC_NOP)) else $error("disabled command ran");
  a_low_half_first: assert property (@(posedge ref_clk) disable iff (!arst_n)
    go && state_q == ST_WDATA && !hi_q && f_valid |=> ad_q == $past(f_data[COL_BITS-1:0]))
    else $error("word half order");
  a_shared_release: assert property (@(posedge ref_clk) disable iff (!arst_n)
    go && state_q == ST_IDLE |=> oe_n_q == SHARED_ACCESS_OPTION) else $error("bus hold");
  c_ref_burst: cover property (@(posedge ref_clk) disable iff (!arst_n) ref_dec ##[1:8] ref_dec);
  c_write_done: cover property (@(posedge ref_clk) disable iff (!arst_n)
    state_q == ST_STOP ##[1:20] done_q);
  c_read_word: cover property (@(posedge ref_clk) disable iff (!arst_n) rvalid_q);
endmodule : sdc_ctrl

// *** rtl/sdc_pkg.sv ***
package sdc_pkg;
  // Geometry
  localparam int ROW_BITS = 12;
  localparam int COL_ADDR_BITS = 8;
  localparam int BANK_BITS = 2;
  localparam int COL_BITS = 16;
  localparam int AD_BITS = 16;
  localparam int WORD_BITS = 2 * COL_BITS;
  localparam int ROW_WORDS = (2 ** COL_ADDR_BITS) / 2;
  // Timing, reference clock at 20 MHz
  localparam int REF_CLK_KHZ = 20000;
  localparam int CLK_DIV = 1;
  localparam int REFRESH_WINDOW_MS = 64;
  localparam int REFRESH_CYCLES = 4096;
  localparam int REF_PERIOD_CYC = REFRESH_WINDOW_MS * REF_CLK_KHZ / REFRESH_CYCLES;
  localparam int MAX_REFRESH_GAP = REFRESH_CYCLES / 8;
  localparam int MIN_REFRESH_SPACING = 2;
  localparam int INIT_US = 200;
  localparam int INIT_CYC = INIT_US * REF_CLK_KHZ / 1000;
  localparam int CAS_LAT = 2;
  localparam int TRCD_TICKS = 2;
  localparam int TRP_TICKS = 2;
  localparam int TWR_TICKS = 2;
  localparam int TMRD_TICKS = 2;
  // Full page burst, CAS latency 2, sequential
  localparam logic [15:0] MODE_REG = 16'h0027;
  localparam logic [15:0] PRE_ALL_AD = 16'h0400;
  localparam logic SHARED_ACCESS_OPTION = 1'b0;
  // Command build enables
  localparam logic EN_WAIT = 1'b1;
  localparam logic EN_BUF_READ = 1'b1;
  localparam logic EN_BUF_WRITE = 1'b1;
  localparam logic EN_ROW_READ = 1'b1;
  localparam logic EN_ROW_WRITE = 1'b1;
  localparam int OWED_W = 13;
  localparam int FIFO_DEPTH = 8;
  // Memory command as {ras_n, cas_n, we_n}
  localparam logic [2:0] MC_NOP = 3'h7;
  localparam logic [2:0] MC_ACT = 3'h3;
  localparam logic [2:0] MC_READ = 3'h5;
  localparam logic [2:0] MC_WRITE = 3'h4;
  localparam logic [2:0] MC_BST = 3'h6;
  localparam logic [2:0] MC_PRE = 3'h2;
  localparam logic [2:0] MC_REF = 3'h1;
  localparam logic [2:0] MC_MRS = 3'h0;
  typedef enum logic [2:0] {
    OP_WAIT = 3'h0, OP_BUF_READ = 3'h1, OP_BUF_WRITE = 3'h2,
    OP_ROW_READ = 3'h3, OP_ROW_WRITE = 3'h4
  } sdc_op_t;
  typedef enum logic [9:0] {
    ST_INIT = 10'h001, ST_MRS = 10'h002, ST_IDLE = 10'h004, ST_REF = 10'h008,
    ST_ACT = 10'h010, ST_XCMD = 10'h020, ST_WDATA = 10'h040, ST_RDATA = 10'h080,
    ST_STOP = 10'h100, ST_CLOSE = 10'h200
  } sdc_state_t;
endpackage : sdc_pkg

// *** verif/sdc_mem_model.sv ***
`timescale 1ns/100ps
// Behavioural single data rate memory; assumes CAS latency 2 and full-page bursts
module sdc_mem_model import sdc_pkg::*; (
  input wire logic mem_clk,
  input wire logic mem_cke,
  input wire logic mem_cs_n,
  input wire logic mem_ras_n,
  input wire logic mem_cas_n,
  input wire logic mem_we_n,
  input wire logic [BANK_BITS-1:0] mem_ba,
  input wire logic mem_dqm,
  input wire logic [AD_BITS-1:0] mem_ad_out,
  input wire logic mem_ad_oe_n,
  output logic [AD_BITS-1:0] mem_ad_in,
  output logic [15:0] mode_q,
  output int ref_cnt,
  output int min_gap,
  output int act_cnt,
  output int bad_ref
);
  localparam int KW = BANK_BITS + ROW_BITS + COL_ADDR_BITS;
  logic [COL_BITS-1:0] store [logic [KW-1:0]];
  logic [ROW_BITS-1:0] row_q [2**BANK_BITS];
  logic [BANK_BITS-1:0] ba_q;
  logic [COL_ADDR_BITS-1:0] col_q;
  logic wr_on = 1'b0;
  logic rd_on = 1'b0;
  logic open_q = 1'b0;
  logic [2:0] cmd;
  logic [AD_BITS-1:0] ad;
  int gap = 1000;

  // Command decode in the controller's own encoding
  assign cmd = {mem_ras_n, mem_cas_n, mem_we_n};
  // Lines the controller has released read as unknown, so a missing drive shows up
  assign ad = mem_ad_oe_n ? {AD_BITS{1'bx}} : mem_ad_out;

  // Counters start clear; the gap starts large so the first refresh is not a short one
  initial begin
    mem_ad_in = 16'h0000;
    mode_q = 16'h0000;
    ref_cnt = 0;
    min_gap = 1000;
    act_cnt = 0;
    bad_ref = 0;
  end

  function automatic logic [KW-1:0] key(input logic [COL_ADDR_BITS-1:0] c);
    return {ba_q, row_q[ba_q], c};
  endfunction : key

  // Each rising memory clock: launch read data, take the command, then the write beat
  always @(posedge mem_clk) begin
    gap++;
    if (rd_on) begin
      // One clock of launch delay gives the CAS latency of 2
      mem_ad_in <= store.exists(key(col_q)) ? store[key(col_q)] : 16'h0000;
      col_q++;
    end else begin
      mem_ad_in <= ~mem_ad_in; // Released lines never keep the last value
    end
    if (mem_cke && !mem_cs_n) begin
      case (cmd)
        MC_ACT: begin
          row_q[mem_ba] = ad[ROW_BITS-1:0];
          open_q = 1'b1;
          act_cnt++;
        end
        MC_READ, MC_WRITE: begin // Column address shares the data lines
          ba_q = mem_ba;
          col_q = ad[COL_ADDR_BITS-1:0];
          rd_on = (cmd == MC_READ);
          wr_on = (cmd == MC_WRITE);
        end
        MC_BST: begin
          rd_on = 1'b0;
          wr_on = 1'b0;
        end
        MC_PRE: begin
          rd_on = 1'b0;
          wr_on = 1'b0;
          open_q = 1'b0;
        end
        MC_REF: begin // Spacing and open-row refreshes recorded
          ref_cnt++;
          if (gap < min_gap) min_gap = gap;
          gap = 0;
          if (open_q) bad_ref++;
        end
        MC_MRS: mode_q = ad;
        default: ;
      endcase
    end
    // Write beats, first one on the command itself; a high mask skips the column
    if (wr_on) begin
      if (!mem_dqm) store[key(col_q)] = ad;
      col_q++;
    end
  end
endmodule : sdc_mem_model

// *** verif/testbench.sv ***
`timescale 1ns/100ps
// Command-level bench: start-up, idle and unknown ops, buffer and full row transfers
module testbench import sdc_pkg::*;;
  localparam int KW = BANK_BITS + ROW_BITS + COL_ADDR_BITS;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [BANK_BITS-1:0] cmd_bank = 2'h0;
  logic [ROW_BITS-1:0] cmd_row = 12'h000;
  logic [COL_ADDR_BITS-1:0] cmd_col = 8'h00;
  logic [COL_ADDR_BITS-1:0] cmd_words = 8'h00;
  logic wr_valid = 1'b0;
  logic [WORD_BITS-1:0] wr_data = 32'h0000_0000;
  logic cmd_ready, cmd_done, wr_ready, rd_valid, mem_clk, mem_cke, mem_cs_n;
  logic mem_ras_n, mem_cas_n, mem_we_n, mem_dqm, mem_ad_oe_n;
  logic [WORD_BITS-1:0] rd_data;
  logic [BANK_BITS-1:0] mem_ba;
  logic [AD_BITS-1:0] mem_ad_out, mem_ad_in;
  logic [15:0] mode_q;
  int ref_cnt, min_gap, act_cnt, bad_ref, acts;
  int err_count = 0;
  int checks = 0;
  logic [WORD_BITS-1:0] rd_q [$];
  realtime t0;

  sdc_ctrl dut (.ref_clk(ref_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_bank(cmd_bank), .cmd_row(cmd_row),
    .cmd_col(cmd_col), .cmd_words(cmd_words), .cmd_done(cmd_done), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
    .mem_clk(mem_clk), .mem_cke(mem_cke), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n),
    .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_dqm(mem_dqm),
    .mem_ad_out(mem_ad_out), .mem_ad_in(mem_ad_in), .mem_ad_oe_n(mem_ad_oe_n));

  sdc_mem_model mem (.mem_clk(mem_clk), .mem_cke(mem_cke), .mem_cs_n(mem_cs_n),
    .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_ba(mem_ba),
    .mem_dqm(mem_dqm), .mem_ad_out(mem_ad_out), .mem_ad_oe_n(mem_ad_oe_n),
    .mem_ad_in(mem_ad_in), .mode_q(mode_q), .ref_cnt(ref_cnt), .min_gap(min_gap),
    .act_cnt(act_cnt), .bad_ref(bad_ref));

  // 20 MHz reference clock
  always #25 ref_clk = ~ref_clk;

  // Read words have no back-pressure, so every pulse is caught here
  always @(posedge ref_clk) if (rd_valid === 1'b1) rd_q.push_back(rd_data);

  task automatic wrap_up;
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic timeout(input string what);
    err_count++;
    $display("FAIL %s expected completion seen timeout", what);
    wrap_up();
  endtask : timeout

  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk32

  task automatic chk1(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  function automatic logic [WORD_BITS-1:0] pat(input int k);
    return {16'(k) ^ 16'hA5A5, 16'(k) + 16'h1000};
  endfunction : pat

  // Offer one command and hold it until the edge that takes it
  task automatic issue(input logic [2:0] op, input logic [BANK_BITS-1:0] ba,
      input logic [ROW_BITS-1:0] row, input logic [COL_ADDR_BITS-1:0] col,
      input logic [COL_ADDR_BITS-1:0] n);
    int i;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_bank <= ba;
    cmd_row <= row;
    cmd_col <= col;
    cmd_words <= n;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (cmd_ready !== 1'b1 && i < 20000);
    if (cmd_ready !== 1'b1) timeout("cmd_ready");
    cmd_valid <= 1'b0;
  endtask : issue

  task automatic wait_done(input int bound);
    int i;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (cmd_done !== 1'b1 && i < bound);
    if (cmd_done !== 1'b1) timeout("cmd_done");
  endtask : wait_done

  // Stream words into the write buffer; valid stays up between words
  task automatic push(input int n, input int base);
    int i;
    @(posedge ref_clk);
    for (int k = 0; k < n; k++) begin
      wr_valid <= 1'b1;
      wr_data <= pat(base + k);
      i = 0;
      do begin
        @(posedge ref_clk);
        i++;
      end while (wr_ready !== 1'b1 && i < 5000);
      if (wr_ready !== 1'b1) timeout("wr_ready");
    end
    wr_valid <= 1'b0;
  endtask : push

  task automatic chk_mem(input logic [BANK_BITS-1:0] ba, input logic [ROW_BITS-1:0] row,
      input logic [COL_ADDR_BITS-1:0] col, input logic [31:0] w);
    logic [KW-1:0] k;
    k = {ba, row, col};
    chk32("low column", {16'h0000, w[15:0]},
      mem.store.exists(k) ? {16'h0000, mem.store[k]} : 32'hFFFF_FFFF);
    k = {ba, row, col + 8'h01};
    chk32("high column", {16'h0000, w[31:16]},
      mem.store.exists(k) ? {16'h0000, mem.store[k]} : 32'hFFFF_FFFF);
  endtask : chk_mem

  task automatic rd_check(input int n, input int base);
    chk32("read word count", 32'(n), 32'(rd_q.size()));
    foreach (rd_q[i]) chk32("read word", pat(base + i), rd_q[i]);
    rd_q.delete();
  endtask : rd_check

  // Watchdog: a hang ends the run as a mismatch
  initial begin
    repeat (60000) @(posedge ref_clk);
    timeout("run length");
  end

  // Main sequence
  initial begin
    int i;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    i = 0;
    while (cmd_ready !== 1'b1 && i < 20000) begin
      @(posedge ref_clk);
      i++;
    end
    if (cmd_ready !== 1'b1) timeout("start-up");
    chk32("mode value", {16'h0000, MODE_REG}, {16'h0000, mode_q});
    chk1("start-up refreshes", 1'b1, 1'(ref_cnt >= MAX_REFRESH_GAP));
    chk1("refresh spacing", 1'b1, 1'(min_gap >= MIN_REFRESH_SPACING));
    @(posedge mem_clk);
    t0 = $realtime;
    @(posedge mem_clk);
    chk32("memory clock period", 32'(2 * CLK_DIV * 50), 32'(int'($realtime - t0)));
    // Idle wait and an unknown op are answered without memory traffic
    acts = act_cnt;
    issue(OP_WAIT, 2'h0, 12'h000, 8'h00, 8'h00);
    wait_done(50);
    issue(3'h5, 2'h0, 12'h000, 8'h00, 8'h00);
    wait_done(50);
    chk32("activations", 32'(acts), 32'(act_cnt));
    // One word: the lead column stays masked, halves land low first
    push(1, 0);
    issue(OP_BUF_WRITE, 2'h2, 12'h7FF, 8'h05, 8'h01);
    wait_done(500);
    chk1("masked lead column", 1'b0, 1'(mem.store.exists({2'h2, 12'h7FF, 8'h04})));
    chk_mem(2'h2, 12'h7FF, 8'h05, pat(0));
    issue(OP_BUF_READ, 2'h2, 12'h7FF, 8'h05, 8'h01);
    wait_done(500);
    rd_check(1, 0);
    // Second word late: the burst halts and reopens at the next column
    fork
      issue(OP_BUF_WRITE, 2'h0, 12'h010, 8'h20, 8'h02);
      begin
        push(1, 300);
        repeat (60) @(posedge ref_clk);
        push(1, 301);
      end
    join
    wait_done(2000);
    chk_mem(2'h0, 12'h010, 8'h20, pat(300));
    chk_mem(2'h0, 12'h010, 8'h22, pat(301));
    // Buffer filled until refused, then a burst that wraps at the row end
    push(FIFO_DEPTH, 16);
    @(posedge ref_clk);
    #1;
    chk1("full buffer ready", 1'b0, wr_ready);
    issue(OP_BUF_WRITE, 2'h1, 12'h003, 8'hF8, 8'h08);
    wait_done(2000);
    chk1("drained buffer ready", 1'b1, wr_ready);
    chk_mem(2'h1, 12'h003, 8'h00, pat(20));
    issue(OP_BUF_READ, 2'h1, 12'h003, 8'hF8, 8'h08);
    wait_done(2000);
    rd_check(8, 16);
    // Full rows ignore the given column and move the whole row
    fork
      push(ROW_WORDS, 100);
      begin
        issue(OP_ROW_WRITE, 2'h3, 12'hABC, 8'h33, 8'h05);
        wait_done(5000);
      end
    join
    chk_mem(2'h3, 12'hABC, 8'h00, pat(100));
    chk_mem(2'h3, 12'hABC, 8'hFE, pat(100 + ROW_WORDS - 1));
    issue(OP_ROW_READ, 2'h3, 12'hABC, 8'h40, 8'h02);
    wait_done(5000);
    rd_check(ROW_WORDS, 100);
    chk32("refresh with open row", 32'h0000_0000, 32'(bad_ref));
    wrap_up();
  end
endmodule : testbench
